//--- src/dif_input_logic.sv
// digital input function logic of the drive
// assumes inputs synchronous to clk_sys; the parameter port is the
// drive's internal fieldbus parameter access, one request per cycle
// Operation
// - free input acts nothing, level stays readable
// - fault reset input clears pending error
// - enable input activates power amplifier
// - halt input halts current movement
// - power removal inputs trigger safety function
// - start input drives control word new setpoint
// - positioning runs on start input rising edge
// - unexecutable positioning reports no error
// - past positive switch, block positive references
// - motor-move enables only jog, speed, gear
// - negative motor-move enable mirrors positive one
// - speed limitation input clamps speed to limit
// - speed limit 16 bit, 1 to 9999
// - current mode keeps limit at least 100
// - jog inputs move clockwise and counterclockwise
// - jog fast/slow input selects jog speed
// - secondary enable only with digital position interface
// - sequence start meets global transition condition
// - sequence select picks and starts data set 0
// - limit and reference switches feed homing logic
// - status word: one bit per input level
module dif_input_logic (
  input  wire logic              clk_sys,
  input  wire logic              resetn,
  input  wire logic [6:0]        di_level,
  input  wire logic              fieldbus_ctrl,
  input  wire dif_pkg::dif_mode_e op_mode,
  input  wire logic [4:0]        func_in1,
  input  wire logic [4:0]        func_in2,
  input  wire logic [4:0]        func_li4,
  input  wire logic [4:0]        func_li7,
  input  wire logic [1:0]        position_interface_select,
  input  wire logic              operation_enabled,
  input  wire logic              seq_waiting,
  input  wire logic [15:0]       drive_control_word_in,
  input  wire logic signed [31:0] ref_in,
  input  wire logic [15:0]       par_addr,
  input  wire logic              par_wr_en,
  input  wire logic              par_rd_en,
  input  wire logic [15:0]       par_wdata,
  output logic [15:0]            par_rdata_q,
  output logic                   par_ack_q,
  output logic                   par_err_q,
  output logic [15:0]            drive_control_word_q,
  output logic                   amp_enable_q,
  output logic                   fault_reset_q,
  output logic                   halt_q,
  output logic                   power_removal_q,
  output logic                   speed_limit_active_q,
  output logic [15:0]            speed_limit_eff_q,
  output logic                   jog_cw_q,
  output logic                   jog_ccw_q,
  output logic                   jog_fast_q,
  output logic signed [31:0]     ref_out_q,
  output logic                   motor_stop_q,
  output logic                   seq_transition_q,
  output logic                   seq_select_ds0_q,
  output logic                   seq_start_ds0_q,
  output logic                   negative_limit_switch_q,
  output logic                   positive_limit_switch_q,
  output logic                   ref_switch_q
);
  import dif_pkg::*;

  // ---------------------------------------------------------------
  // function decode
  // ---------------------------------------------------------------
  logic [FN-1:0] asg1, asg2, asg4, asg7;
  logic [FN-1:0] act1, act2, act4, act7;
  logic [FN-1:0] asg, act;

  dif_func_decode #(.ALLOW_MASK(ALLOW_IN1)) u_dec_in1 (
    .level    (di_level[DI_IN1]),
    .code     (func_in1),
    .assigned (asg1),
    .active   (act1)
  );
  dif_func_decode #(.ALLOW_MASK(ALLOW_IN2)) u_dec_in2 (
    .level    (di_level[DI_IN2]),
    .code     (func_in2),
    .assigned (asg2),
    .active   (act2)
  );
  dif_func_decode #(.ALLOW_MASK(ALLOW_LI4)) u_dec_li4 (
    .level    (di_level[DI_LI4]),
    .code     (func_li4),
    .assigned (asg4),
    .active   (act4)
  );
  dif_func_decode #(.ALLOW_MASK(ALLOW_LI7)) u_dec_li7 (
    .level    (di_level[DI_LI7]),
    .code     (func_li7),
    .assigned (asg7),
    .active   (act7)
  );

  // free inputs decode to no bit at all, so only the status word sees them
  assign asg = asg1 | asg2 | asg4 | asg7;
  assign act = act1 | act2 | act4 | act7;

  // ---------------------------------------------------------------
  // mode qualifiers
  // ---------------------------------------------------------------
  logic m_move_en, m_jog, m_spd, m_seq, m_pp, m_cur;
  logic li3_enable, li3_pos_lim, pos_lock, neg_lock;
  logic start_act, start_q, start_rise, sel_pend_q;

  assign m_jog = (op_mode == MODE_JOG) && !fieldbus_ctrl;
  assign m_cur = (op_mode == MODE_CURRENT);
  assign m_spd = !fieldbus_ctrl && (op_mode == MODE_GEAR ||
                 op_mode == MODE_SPEED || m_cur);
  assign m_seq = (op_mode == MODE_SEQUENCE);
  assign m_pp  = (op_mode == MODE_PROFILE_POS) && fieldbus_ctrl;
  assign m_move_en = !fieldbus_ctrl && (op_mode == MODE_JOG ||
                     op_mode == MODE_GEAR || op_mode == MODE_SPEED);

  // the fixed third input is enable locally, positive limit on fieldbus
  assign li3_enable = di_level[DI_LI3] && !fieldbus_ctrl;
  assign li3_pos_lim = di_level[DI_LI3] && fieldbus_ctrl;

  // switch input low means the switching edge has been passed
  assign pos_lock = m_move_en && asg[FI_POS_EN] && !act[FI_POS_EN];
  assign neg_lock = m_move_en && asg[FI_NEG_EN] && !act[FI_NEG_EN];

  // ---------------------------------------------------------------
  // parameter storage and access
  // ---------------------------------------------------------------
  logic [15:0] speed_limit_q;
  logic        lim_ok;

  assign lim_ok = (par_wdata >= SPEED_LIMIT_MIN) && (par_wdata <= SPEED_LIMIT_MAX);

  // out-of-range writes are refused so the stored value stays legal
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      speed_limit_q <= SPEED_LIMIT_RST;
    end else if (par_wr_en && par_addr == SPEED_LIMIT_OFS && lim_ok) begin
      speed_limit_q <= par_wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      par_rdata_q <= STATUS_RST;
      par_ack_q   <= 1'b0;
      par_err_q   <= 1'b0;
    end else begin
      par_ack_q <= par_wr_en || par_rd_en;
      par_err_q <= 1'b0;
      if (par_wr_en) begin
        par_err_q <= !(par_addr == SPEED_LIMIT_OFS && lim_ok);
      end else if (par_rd_en) begin
        case (par_addr)
          INPUT_STATUS_OFS: par_rdata_q <= {9'h000, di_level};
          SPEED_LIMIT_OFS:  par_rdata_q <= speed_limit_q;
          default: begin
            par_rdata_q <= 16'h0000;
            par_err_q   <= 1'b1;
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // state and safety related outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      amp_enable_q    <= 1'b0;
      fault_reset_q   <= 1'b0;
      halt_q          <= 1'b0;
      power_removal_q <= 1'b1;
    end else begin
      amp_enable_q    <= li3_enable ||
                         (act[FI_SEC_EN] &&
                          position_interface_select == POS_IF_DIGITAL_INPUT);
      fault_reset_q   <= act[FI_FAULT];
      halt_q          <= act[FI_HALT];
      // both channels are active low; either one low removes power
      power_removal_q <= !di_level[DI_LI5] || !di_level[DI_LI6];
    end
  end

  // ---------------------------------------------------------------
  // profile positioning start
  // ---------------------------------------------------------------
  assign start_act  = act[FI_START];
  assign start_rise = start_act && !start_q;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      start_q <= 1'b0;
    end else begin
      start_q <= start_act;
    end
  end

  // an edge outside operation enabled is dropped silently, no fault flag
  logic dig_start;
  assign dig_start = start_rise && m_pp && operation_enabled;

  // the master keeps its own start bit low while the input is in use
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      drive_control_word_q <= 16'h0000;
    end else begin
      drive_control_word_q <= drive_control_word_in;
      drive_control_word_q[CW_NEW_SETPOINT] <=
        drive_control_word_in[CW_NEW_SETPOINT] || dig_start;
    end
  end

  // ---------------------------------------------------------------
  // speed limitation and jog
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      speed_limit_active_q <= 1'b0;
      speed_limit_eff_q    <= SPEED_LIMIT_RST;
      jog_cw_q             <= 1'b0;
      jog_ccw_q            <= 1'b0;
      jog_fast_q           <= 1'b0;
    end else begin
      speed_limit_active_q <= m_spd && act[FI_SPD_LIM];
      if (m_cur && speed_limit_q < CURRENT_MODE_MIN) begin
        speed_limit_eff_q <= CURRENT_MODE_MIN;
      end else begin
        speed_limit_eff_q <= speed_limit_q;
      end
      // both jog directions at once cancel rather than pick a winner
      jog_cw_q   <= m_jog && act[FI_JOG_POS] && !act[FI_JOG_NEG];
      jog_ccw_q  <= m_jog && act[FI_JOG_NEG] && !act[FI_JOG_POS];
      jog_fast_q <= m_jog && act[FI_JOG_FST];
    end
  end

  // ---------------------------------------------------------------
  // reference gating by position switches
  // ---------------------------------------------------------------
  logic ref_pos, ref_neg, blocked;

  assign ref_pos = (ref_in > 32'sd0);
  assign ref_neg = (ref_in < 32'sd0);
  assign blocked = (pos_lock && ref_pos) || (neg_lock && ref_neg);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ref_out_q    <= 32'sh0000_0000;
      motor_stop_q <= 1'b0;
    end else begin
      ref_out_q    <= blocked ? 32'sh0000_0000 : ref_in;
      motor_stop_q <= blocked;
    end
  end

  // ---------------------------------------------------------------
  // motion sequence
  // ---------------------------------------------------------------
  logic seq_trans;
  assign seq_trans = m_seq && act[FI_SEQ_ST];

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sel_pend_q <= 1'b0;
    end else if (sel_pend_q && seq_trans) begin
      sel_pend_q <= 1'b0;
    end else if (m_seq && seq_waiting && act[FI_SEQ_SEL]) begin
      sel_pend_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      seq_transition_q <= 1'b0;
      seq_select_ds0_q <= 1'b0;
      seq_start_ds0_q  <= 1'b0;
    end else begin
      seq_transition_q <= seq_trans;
      seq_select_ds0_q <= sel_pend_q && !seq_trans;
      seq_start_ds0_q  <= sel_pend_q && seq_trans;
    end
  end

  // ---------------------------------------------------------------
  // switch signals for homing and positioning range
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      negative_limit_switch_q <= 1'b0;
      positive_limit_switch_q <= 1'b0;
      ref_switch_q            <= 1'b0;
    end else begin
      negative_limit_switch_q <= act[FI_NEG_LIM];
      positive_limit_switch_q <= li3_pos_lim;
      ref_switch_q            <= act[FI_REF];
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence s_start_edge;
    !start_act ##1 (start_act && m_pp && operation_enabled);
  endsequence

  sequence s_ds0_go;
    sel_pend_q && seq_trans;
  endsequence

  chk_status_read: assert property (
    par_rd_en && !par_wr_en && par_addr == INPUT_STATUS_OFS |=>
      par_rdata_q == {9'h000, $past(di_level)} && par_ack_q && !par_err_q)
    else $error("status word does not mirror input levels");

  chk_power_remove: assert property (
    (!di_level[DI_LI5] || !di_level[DI_LI6]) |=> power_removal_q)
    else $error("power removal not raised");

  chk_start_edge: assert property (
    s_start_edge |=> drive_control_word_q[CW_NEW_SETPOINT])
    else $error("start edge did not set new setpoint");

  chk_start_single: assert property (
    start_act && !drive_control_word_in[CW_NEW_SETPOINT] ##1
      start_act && !drive_control_word_in[CW_NEW_SETPOINT] |=>
      !drive_control_word_q[CW_NEW_SETPOINT])
    else $error("held start level restarted positioning");

  chk_start_quiet: assert property (
    !operation_enabled && !drive_control_word_in[CW_NEW_SETPOINT] |=>
      !drive_control_word_q[CW_NEW_SETPOINT])
    else $error("start passed without operation enabled");

  chk_pos_block: assert property (
    pos_lock && ref_pos |=> ref_out_q == 32'sh0000_0000 && motor_stop_q)
    else $error("positive reference not blocked");

  chk_neg_block: assert property (
    neg_lock && ref_neg |=> ref_out_q == 32'sh0000_0000 && motor_stop_q)
    else $error("negative reference not blocked");

  chk_neg_passes: assert property (
    pos_lock && !neg_lock && ref_neg |=> ref_out_q == $past(ref_in) && !motor_stop_q)
    else $error("negative reference lost while positive locked");

  chk_move_modes: assert property (
    !m_move_en |=> !motor_stop_q && ref_out_q == $past(ref_in))
    else $error("move enable active outside jog speed gear");

  chk_limit_range: assert property (
    speed_limit_q >= SPEED_LIMIT_MIN && speed_limit_q <= SPEED_LIMIT_MAX)
    else $error("stored speed limit out of range");

  chk_current_floor: assert property (
    m_cur |=> speed_limit_eff_q >= CURRENT_MODE_MIN)
    else $error("current mode limit below floor");

  chk_sec_enable: assert property (
    act[FI_SEC_EN] && !li3_enable &&
      position_interface_select != POS_IF_DIGITAL_INPUT |=> !amp_enable_q)
    else $error("secondary enable acted without digital interface");

  chk_ds0_start: assert property (
    s_ds0_go |=> seq_start_ds0_q && !seq_select_ds0_q ##1 !seq_start_ds0_q)
    else $error("data set 0 start not a single pulse");

endmodule

//--- common/dif_pkg.sv
// constants and types for the drive input function logic
// assumes one 40 mhz clock domain shared with the drive's control logic
package dif_pkg;

  // ---------------------------------------------------------------
  // parameter map
  // ---------------------------------------------------------------
  localparam logic [15:0] SPEED_LIMIT_OFS  = 16'h063c;
  localparam logic [15:0] INPUT_STATUS_OFS = 16'h081e;
  localparam logic [15:0] SPEED_LIMIT_RST  = 16'h000a;
  localparam logic [15:0] SPEED_LIMIT_MIN  = 16'h0001;
  localparam logic [15:0] SPEED_LIMIT_MAX  = 16'h270f;
  localparam logic [15:0] CURRENT_MODE_MIN = 16'h0064;
  localparam logic [15:0] STATUS_RST       = 16'h0000;

  // ---------------------------------------------------------------
  // digital input positions in the level vector and status word
  // ---------------------------------------------------------------
  localparam int DI_W   = 7;
  localparam int DI_IN1 = 0;
  localparam int DI_IN2 = 1;
  localparam int DI_LI3 = 2;
  localparam int DI_LI4 = 3;
  localparam int DI_LI5 = 4;
  localparam int DI_LI6 = 5;
  localparam int DI_LI7 = 6;
  localparam int CW_NEW_SETPOINT = 4;

  // ---------------------------------------------------------------
  // function codes of a configurable input
  // ---------------------------------------------------------------
  localparam logic [4:0] FC_FREE        = 5'h01;
  localparam logic [4:0] FC_FAULT_RESET = 5'h02;
  localparam logic [4:0] FC_HALT        = 5'h04;
  localparam logic [4:0] FC_START_PP    = 5'h05;
  localparam logic [4:0] FC_POS_EN      = 5'h06;
  localparam logic [4:0] FC_NEG_EN      = 5'h07;
  localparam logic [4:0] FC_SPD_LIM     = 5'h08;
  localparam logic [4:0] FC_JOG_POS     = 5'h09;
  localparam logic [4:0] FC_JOG_NEG     = 5'h0a;
  localparam logic [4:0] FC_JOG_FAST    = 5'h0b;
  localparam logic [4:0] FC_SEQ_START   = 5'h0d;
  localparam logic [4:0] FC_SEQ_SELECT  = 5'h0e;
  localparam logic [4:0] FC_SEC_EN      = 5'h0f;
  localparam logic [4:0] FC_REF         = 5'h14;
  localparam logic [4:0] FC_POS_LIM     = 5'h15;
  localparam logic [4:0] FC_NEG_LIM     = 5'h16;

  // ---------------------------------------------------------------
  // one-hot function vector positions
  // ---------------------------------------------------------------
  localparam int FN         = 15;
  localparam int FI_FAULT   = 0;
  localparam int FI_HALT    = 1;
  localparam int FI_START   = 2;
  localparam int FI_POS_EN  = 3;
  localparam int FI_NEG_EN  = 4;
  localparam int FI_SPD_LIM = 5;
  localparam int FI_JOG_POS = 6;
  localparam int FI_JOG_NEG = 7;
  localparam int FI_JOG_FST = 8;
  localparam int FI_SEQ_ST  = 9;
  localparam int FI_SEQ_SEL = 10;
  localparam int FI_REF     = 11;
  localparam int FI_POS_LIM = 12;
  localparam int FI_NEG_LIM = 13;
  localparam int FI_SEC_EN  = 14;

  // functions each configurable input may take
  localparam logic [FN-1:0] ALLOW_IN1 = 15'h0fff;
  localparam logic [FN-1:0] ALLOW_IN2 = 15'h27ff;
  localparam logic [FN-1:0] ALLOW_LI4 = 15'h07ff;
  localparam logic [FN-1:0] ALLOW_LI7 = 15'h47ff;

  localparam logic [1:0] POS_IF_DIGITAL_INPUT = 2'h1;

  typedef enum logic [2:0] {
    MODE_JOG,
    MODE_GEAR,
    MODE_SPEED,
    MODE_CURRENT,
    MODE_SEQUENCE,
    MODE_PROFILE_POS,
    MODE_HOMING
  } dif_mode_e;

endpackage

//--- src/dif_func_decode.sv
// decoder for one configurable digital input
// assumes code and level are stable, synchronous inputs
module dif_func_decode #(
  parameter logic [14:0] ALLOW_MASK = 15'h7fff
) (
  input  wire logic        level,
  input  wire logic [4:0]  code,
  output logic      [14:0] assigned,
  output logic      [14:0] active
);
  import dif_pkg::*;

  logic [FN-1:0] hit;

  always_comb begin
    hit = '0;
    case (code)
      FC_FAULT_RESET: hit[FI_FAULT]   = 1'b1;
      FC_HALT:        hit[FI_HALT]    = 1'b1;
      FC_START_PP:    hit[FI_START]   = 1'b1;
      FC_POS_EN:      hit[FI_POS_EN]  = 1'b1;
      FC_NEG_EN:      hit[FI_NEG_EN]  = 1'b1;
      FC_SPD_LIM:     hit[FI_SPD_LIM] = 1'b1;
      FC_JOG_POS:     hit[FI_JOG_POS] = 1'b1;
      FC_JOG_NEG:     hit[FI_JOG_NEG] = 1'b1;
      FC_JOG_FAST:    hit[FI_JOG_FST] = 1'b1;
      FC_SEQ_START:   hit[FI_SEQ_ST]  = 1'b1;
      FC_SEQ_SELECT:  hit[FI_SEQ_SEL] = 1'b1;
      FC_REF:         hit[FI_REF]     = 1'b1;
      FC_NEG_LIM:     hit[FI_NEG_LIM] = 1'b1;
      FC_SEC_EN:      hit[FI_SEC_EN]  = 1'b1;
      default:        hit = '0;
    endcase
  end

  // codes the input may not carry, and the free code, decode to nothing
  assign assigned = hit & ALLOW_MASK;
  assign active   = level ? assigned : '0;

endmodule

//--- sim/dif_switch_model.sv
// model of the switches and controller wired to the digital inputs
// assumes the bench changes want on the falling clock edge
module dif_switch_model (
  input  wire logic       cw_start,
  input  wire logic [6:0] start_mask,
  input  wire logic [6:0] want,
  output logic      [6:0] di_level
);
  timeunit 1ns;
  timeprecision 1ps;
  // start level withheld while the control word starts a move
  assign di_level = want & ~(cw_start ? start_mask : 7'h00);
endmodule

//--- sim/test_dif_input_logic.sv
// bench for the drive input function logic
// assumes the switch model in front of di_level, one 40 mhz clock
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin err_count++; \
  $display("ERROR at %0t: got %h expected %h", $time, got, exp); end end
module test_dif_input_logic;
  timeunit 1ns;
  timeprecision 1ps;
  import dif_pkg::*;
  logic clk_sys = 1'b0, resetn = 1'b0, fieldbus_ctrl = 1'b0, operation_enabled = 1'b0, seq_waiting = 1'b0;
  logic cw_start = 1'b0, par_wr_en = 1'b0, par_rd_en = 1'b0;
  logic [6:0] want = 7'h30, di_level;
  logic [4:0] func_in1 = FC_FREE, func_in2 = FC_FREE, func_li4 = FC_FREE, func_li7 = FC_FREE;
  logic [1:0] position_interface_select = 2'h0;
  logic [15:0] drive_control_word_in = 16'h0000, par_addr = 16'h0000, par_wdata = 16'h0000;
  logic signed [31:0] ref_in = 32'sh00000000, ref_out_q;
  dif_mode_e op_mode = MODE_SPEED;
  logic [15:0] par_rdata_q, drive_control_word_q, speed_limit_eff_q;
  logic par_ack_q, par_err_q, amp_enable_q, fault_reset_q, halt_q, power_removal_q, speed_limit_active_q;
  logic jog_cw_q, jog_ccw_q, jog_fast_q, motor_stop_q, seq_transition_q, seq_select_ds0_q, seq_start_ds0_q;
  logic negative_limit_switch_q, positive_limit_switch_q, ref_switch_q;
  int err_count = 0;
  int total_checks = 0;

  always #12.5 clk_sys = ~clk_sys;

  dif_switch_model u_sw (.cw_start(cw_start), .start_mask(7'h08), .want(want), .di_level(di_level));

  dif_input_logic DUT (.clk_sys, .resetn, .di_level, .fieldbus_ctrl, .op_mode, .func_in1, .func_in2,
    .func_li4, .func_li7, .position_interface_select, .operation_enabled, .seq_waiting, .drive_control_word_in,
    .ref_in, .par_addr, .par_wr_en, .par_rd_en, .par_wdata, .par_rdata_q, .par_ack_q, .par_err_q,
    .drive_control_word_q, .amp_enable_q, .fault_reset_q, .halt_q, .power_removal_q, .speed_limit_active_q,
    .speed_limit_eff_q, .jog_cw_q, .jog_ccw_q, .jog_fast_q, .ref_out_q, .motor_stop_q, .seq_transition_q,
    .seq_select_ds0_q, .seq_start_ds0_q, .negative_limit_switch_q, .positive_limit_switch_q, .ref_switch_q);

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic tick();
    @(negedge clk_sys);
  endtask

  // answer is fixed one cycle after the request; strobes rest a cycle between calls
  task automatic par(input logic wr, input logic [15:0] a, input logic [15:0] d, input logic e);
    par_addr = a;
    par_wdata = d;
    par_wr_en = wr;
    par_rd_en = !wr;
    tick();
    `CHK(par_ack_q, 1'b1)
    `CHK(par_err_q, e)
    par_wr_en = 1'b0;
    par_rd_en = 1'b0;
    tick();
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_param();
    `CHK(power_removal_q, 1'b1)
    `CHK(speed_limit_eff_q, SPEED_LIMIT_RST)
    par(1'b0, SPEED_LIMIT_OFS, 16'h0000, 1'b0);
    `CHK(par_rdata_q, SPEED_LIMIT_RST)
    par(1'b1, SPEED_LIMIT_OFS, 16'h0000, 1'b1);
    par(1'b1, SPEED_LIMIT_OFS, SPEED_LIMIT_MAX, 1'b0);
    par(1'b1, SPEED_LIMIT_OFS, 16'h2710, 1'b1);
    par(1'b0, SPEED_LIMIT_OFS, 16'h0000, 1'b0);
    `CHK(par_rdata_q, SPEED_LIMIT_MAX)
    par(1'b1, INPUT_STATUS_OFS, 16'h0001, 1'b1);
    par(1'b0, 16'h0002, 16'h0000, 1'b1);
    `CHK(par_rdata_q, 16'h0000)
  endtask

  task automatic t_free_basic();
    want = 7'h31;
    tick();
    par(1'b0, INPUT_STATUS_OFS, 16'h0000, 1'b0);
    `CHK(par_rdata_q, 16'h0031)
    `CHK({amp_enable_q, halt_q, fault_reset_q, power_removal_q}, 4'h0)
    func_in2 = FC_FAULT_RESET;
    func_li4 = FC_HALT;
    func_li7 = FC_SEC_EN;
    want = 7'h3e;
    tick();
    `CHK({amp_enable_q, halt_q, fault_reset_q}, 3'h7)
    want = 7'h50;
    tick();
    `CHK(power_removal_q, 1'b1)
    `CHK(amp_enable_q, 1'b0)
    position_interface_select = POS_IF_DIGITAL_INPUT;
    tick();
    `CHK(amp_enable_q, 1'b1)
  endtask

  task automatic t_speed_move();
    par(1'b1, SPEED_LIMIT_OFS, 16'h0032, 1'b0);
    func_in1 = FC_SPD_LIM;
    want = 7'h31;
    tick();
    `CHK({speed_limit_active_q, speed_limit_eff_q}, {1'b1, 16'h0032})
    op_mode = MODE_CURRENT;
    tick();
    `CHK(speed_limit_eff_q, CURRENT_MODE_MIN)
    op_mode = MODE_SPEED;
    func_in1 = FC_POS_EN;
    want = 7'h30;
    ref_in = 32'sh00000064;
    tick();
    `CHK({motor_stop_q, ref_out_q}, {1'b1, 32'sh00000000})
    ref_in = 32'shfffffffb;
    tick();
    `CHK(ref_out_q, 32'shfffffffb)
    func_in1 = FC_NEG_EN;
    tick();
    `CHK(ref_out_q, 32'sh00000000)
    op_mode = MODE_CURRENT;
    tick();
    `CHK(ref_out_q, 32'shfffffffb)
  endtask

  task automatic t_jog();
    op_mode = MODE_JOG;
    func_in1 = FC_JOG_POS;
    func_in2 = FC_JOG_NEG;
    func_li4 = FC_JOG_FAST;
    want = 7'h31;
    tick();
    `CHK({jog_cw_q, jog_ccw_q}, 2'h2)
    want = 7'h3a;
    tick();
    `CHK({jog_cw_q, jog_ccw_q, jog_fast_q}, 3'h3)
  endtask

  task automatic t_start(input logic en, input int exp);
    int n;
    n = 0;
    fieldbus_ctrl = 1'b1;
    op_mode = MODE_PROFILE_POS;
    operation_enabled = en;
    func_in1 = FC_REF;
    func_li4 = FC_START_PP;
    drive_control_word_in = 16'h000f;
    want = 7'h35;
    tick();
    `CHK({ref_switch_q, positive_limit_switch_q}, 2'h3)
    want = 7'h3d;
    repeat (4) begin
      tick();
      if (drive_control_word_q[CW_NEW_SETPOINT] === 1'b1) n++;
      `CHK(par_err_q, 1'b0)
    end
    `CHK(n, exp)
    `CHK(drive_control_word_q[3:0], 4'hf)
    // control word start; the switch side withholds its start level
    cw_start = 1'b1;
    drive_control_word_in = 16'h001f;
    tick();
    `CHK(drive_control_word_q[CW_NEW_SETPOINT], 1'b1)
    par(1'b0, INPUT_STATUS_OFS, 16'h0000, 1'b0);
    `CHK(par_rdata_q, 16'h0035)
    cw_start = 1'b0;
    want = 7'h35;
    drive_control_word_in = 16'h000f;
    tick();
  endtask

  task automatic t_seq();
    fieldbus_ctrl = 1'b0;
    op_mode = MODE_SEQUENCE;
    func_in1 = FC_SEQ_SELECT;
    func_in2 = FC_SEQ_START;
    seq_waiting = 1'b1;
    want = 7'h31;
    tick();
    tick();
    `CHK({seq_select_ds0_q, seq_start_ds0_q}, 2'h2)
    want = 7'h32;
    seq_waiting = 1'b0;
    tick();
    `CHK({seq_transition_q, seq_select_ds0_q, seq_start_ds0_q}, 3'h5)
    tick();
    `CHK({seq_transition_q, seq_select_ds0_q, seq_start_ds0_q}, 3'h4)
    func_in2 = FC_NEG_LIM;
    tick();
    `CHK(negative_limit_switch_q, 1'b1)
    // reset in mid-run brings back the default limit
    resetn = 1'b0;
    tick();
    `CHK({power_removal_q, speed_limit_eff_q, negative_limit_switch_q}, {1'b1, SPEED_LIMIT_RST, 1'b0})
    resetn = 1'b1;
    par(1'b0, SPEED_LIMIT_OFS, 16'h0000, 1'b0);
    `CHK(par_rdata_q, SPEED_LIMIT_RST)
  endtask

  // ---------------------------------------------------------------
  // main sequence and hang guard
  // ---------------------------------------------------------------
  initial begin
    repeat (5) @(negedge clk_sys);
    resetn = 1'b1;
    t_param();
    t_free_basic();
    t_speed_move();
    t_jog();
    t_start(1'b1, 1);
    t_start(1'b0, 0);
    t_seq();
    conclude();
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    conclude();
  end
endmodule
